// >>> ussri_top.sv
// Synchronous slave serial unit with receive FIFO, APB registers and interrupts
`timescale 1ns/1ps

//Contract
// - Receive-pending flag high while unit enabled and FIFO holds an unread character.
// - Receive-pending flag is read only; writes to the flags register never change it.
// - Receive interrupt request needs receive, peripheral and global enables set.
// - Receive-pending flag ignores enables; enables gate only the request.
// - Sync select one plus clock source zero gives external-clock slave.
// - Slave transmits when both receive enables are zero and transmit enable is set; receives when either receive enable is set.
// - Serial port enable turns the unit on; cleared, slave logic idles.
// - Slave transmit matches master transmit except clock source and sleep.
// - Two words before sleep: first shifts out, second waits, ready stays clear.
// - After first character leaves, second moves to shifter, then ready sets.
// - Transmit-ready with peripheral and transmit enables wakes core; global vectors.
// - Nine-bit enable plus ninth bit field; writing low byte starts sending.
// - Received characters enter a two-deep FIFO; a third may be shifting.
// - Reading receive data pops and returns the oldest FIFO character.
module ussri_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        sleep_mode,
    input  wire logic        link_ck,
    input  wire logic        dt_in,
    output logic             dt_out,
    output logic             dt_oe,
    output logic             irq,
    output logic             cpu_irq_req,
    output logic             wake_req
);

    ussri_pkg::ussri_state_t st_reg;
    ussri_pkg::ussri_state_t st_next;

    logic       serial_port_enable;
    logic       slave_mode;
    logic       rx_mode;
    logic       tx_active;
    logic       rx_active;
    logic       rx_pending_flag;
    logic       tx_ready_flag;
    logic       ck_rise;
    logic       ck_fall;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic       wr_done;
    logic       rd_done;
    logic       ev_rx;
    logic       ev_tx;
    logic       ev_ovr;

    assign serial_port_enable = st_reg.receive_status_control[
        ussri_pkg::SERIAL_PORT_ENABLE_BIT];
    assign slave_mode = serial_port_enable
        && st_reg.transmit_status_control[ussri_pkg::SYNC_MODE_BIT]
        && !st_reg.transmit_status_control[
            ussri_pkg::CLOCK_SOURCE_SELECT_BIT];
    assign rx_mode = st_reg.receive_status_control[
                         ussri_pkg::SINGLE_RECEIVE_BIT]
        || st_reg.receive_status_control[ussri_pkg::CONTINUOUS_RECEIVE_BIT];
    assign tx_active = slave_mode && !rx_mode
        && st_reg.transmit_status_control[ussri_pkg::TRANSMIT_ENABLE_BIT];
    // Overrun halts reception until continuous receive is cleared
    assign rx_active = slave_mode && rx_mode
        && !st_reg.receive_status_control[ussri_pkg::OVERRUN_BIT];
    assign rx_pending_flag = serial_port_enable && (st_reg.fifo_cnt != 2'h0);
    assign tx_ready_flag = !st_reg.hold_full;
    // Edges are found only on the second synchroniser stage onward
    assign ck_rise = st_reg.ck_s2 && !st_reg.ck_s3;
    assign ck_fall = !st_reg.ck_s2 && st_reg.ck_s3;
    assign tx_bits = st_reg.transmit_status_control[
        ussri_pkg::TX_NINE_BIT_ENABLE_BIT] ? ussri_pkg::CHAR_BITS_NINE
                                            : ussri_pkg::CHAR_BITS_EIGHT;
    assign rx_bits = st_reg.receive_status_control[
        ussri_pkg::RX_NINE_BIT_ENABLE_BIT] ? ussri_pkg::CHAR_BITS_NINE
                                            : ussri_pkg::CHAR_BITS_EIGHT;
    assign wr_done = psel && penable && st_reg.pready && pwrite;
    assign rd_done = psel && penable && st_reg.pready && !pwrite;

    always_comb begin
        st_next = st_reg;
        ev_rx   = 1'b0;
        ev_tx   = 1'b0;
        ev_ovr  = 1'b0;
        // Link pins pass two flip-flops before use
        st_next.ck_s1 = link_ck;
        st_next.ck_s2 = st_reg.ck_s1;
        st_next.ck_s3 = st_reg.ck_s2;
        st_next.dt_s1 = dt_in;
        st_next.dt_s2 = st_reg.dt_s1;

        // APB: one wait-free access phase, pready one cycle after setup
        st_next.pready  = psel && !penable;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.prdata = 32'h0000_0000;
            unique case (paddr)
                ussri_pkg::OFF_IRQ_CONTROL_MAIN:
                    st_next.prdata[7:0] = st_reg.irq_control_main;
                ussri_pkg::OFF_PERIPH_IRQ_ENABLE:
                    st_next.prdata[7:0] = st_reg.periph_irq_enable_one;
                ussri_pkg::OFF_PERIPH_IRQ_FLAGS: begin
                    st_next.prdata[ussri_pkg::RX_PENDING_FLAG_BIT] = rx_pending_flag;
                    st_next.prdata[ussri_pkg::TX_READY_FLAG_BIT]   = tx_ready_flag;
                end
                ussri_pkg::OFF_RECEIVE_STATUS: begin
                    st_next.prdata[7:0] = st_reg.receive_status_control;
                    st_next.prdata[ussri_pkg::RX_NINTH_BIT] =
                        st_reg.fifo[0][8];
                end
                ussri_pkg::OFF_TRANSMIT_STATUS: begin
                    st_next.prdata[7:0] = st_reg.transmit_status_control;
                    st_next.prdata[ussri_pkg::TX_SHIFT_EMPTY_BIT] =
                        !st_reg.tx_busy;
                end
                ussri_pkg::OFF_TRANSMIT_HOLDING:
                    st_next.prdata[7:0] = st_reg.transmit_holding;
                ussri_pkg::OFF_RECEIVE_DATA:
                    st_next.prdata[7:0] = st_reg.fifo[0][7:0];
                ussri_pkg::OFF_PORT_C_DIRECTION:
                    st_next.prdata[7:0] = st_reg.port_c_direction;
                ussri_pkg::OFF_IRQ_STATUS:
                    st_next.prdata[2:0] = st_reg.irq_stat;
                ussri_pkg::OFF_IRQ_MASK:
                    st_next.prdata[2:0] = st_reg.irq_mask;
                default:
                    st_next.pslverr = 1'b1;
            endcase
        end

        if (wr_done) begin
            unique case (paddr)
                ussri_pkg::OFF_IRQ_CONTROL_MAIN:
                    st_next.irq_control_main = pwdata[7:0];
                ussri_pkg::OFF_PERIPH_IRQ_ENABLE:
                    st_next.periph_irq_enable_one = pwdata[7:0];
                ussri_pkg::OFF_PERIPH_IRQ_FLAGS: ;
                ussri_pkg::OFF_RECEIVE_STATUS: begin
                    st_next.receive_status_control[7:3] = pwdata[7:3];
                    // Clearing continuous receive also clears overrun
                    if (!pwdata[ussri_pkg::CONTINUOUS_RECEIVE_BIT]) begin
                        st_next.receive_status_control[
                            ussri_pkg::OVERRUN_BIT] = 1'b0;
                    end
                end
                ussri_pkg::OFF_TRANSMIT_STATUS: begin
                    st_next.transmit_status_control[7:4] = pwdata[7:4];
                    st_next.transmit_status_control[2]   = pwdata[2];
                    st_next.transmit_status_control[0]   = pwdata[0];
                end
                ussri_pkg::OFF_TRANSMIT_HOLDING: begin
                    st_next.transmit_holding = pwdata[7:0];
                    st_next.hold_ninth = st_reg.transmit_status_control[
                        ussri_pkg::TX_NINTH_BIT];
                    st_next.hold_full = 1'b1;
                end
                ussri_pkg::OFF_PORT_C_DIRECTION:
                    st_next.port_c_direction = pwdata[7:0];
                ussri_pkg::OFF_IRQ_STATUS:
                    st_next.irq_stat = st_reg.irq_stat & ~pwdata[2:0];
                ussri_pkg::OFF_IRQ_MASK:
                    st_next.irq_mask = pwdata[2:0];
                default: ;
            endcase
        end

        if (rd_done && paddr == ussri_pkg::OFF_RECEIVE_DATA
            && st_reg.fifo_cnt != 2'h0) begin
            st_next.fifo[0]  = st_reg.fifo[1];
            st_next.fifo_cnt = st_reg.fifo_cnt - 2'h1;
        end

        if (!tx_active) begin
            st_next.tx_busy = 1'b0;
            st_next.tx_cnt  = 4'h0;
        end else if (st_reg.tx_busy) begin
            // rising edge launches, falling edge shifts; master samples just before its next rising edge
            if (ck_rise) begin
                st_next.dt_out = st_reg.transmit_shift_register[0];
            end
            if (ck_fall) begin
                st_next.transmit_shift_register =
                    {1'b0, st_reg.transmit_shift_register[8:1]};
                st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
                if (st_reg.tx_cnt + 4'h1 == tx_bits) begin
                    st_next.tx_busy = 1'b0;
                    st_next.tx_cnt  = 4'h0;
                end
            end
        end else if (st_reg.hold_full && !wr_done) begin
            // first word goes straight to shifter
            // held word follows, then ready rises
            st_next.transmit_shift_register =
                {st_reg.hold_ninth, st_reg.transmit_holding};
            st_next.tx_busy   = 1'b1;
            st_next.tx_cnt    = 4'h0;
            st_next.hold_full = 1'b0;
            ev_tx             = 1'b1;
        end
        // pin driven only in transmit mode
        st_next.dt_oe = tx_active;

        if (!rx_active) begin
            st_next.rx_cnt = 4'h0;
        end else if (ck_fall) begin
            // receive sample on master clock falling edge
            st_next.rx_shift[st_reg.rx_cnt] = st_reg.dt_s2;
            st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
            if (st_reg.rx_cnt + 4'h1 == rx_bits) begin
                st_next.rx_cnt = 4'h0;
                if (rx_bits == ussri_pkg::CHAR_BITS_EIGHT) begin
                    st_next.rx_shift[8] = 1'b0;
                end
                if (st_next.fifo_cnt == ussri_pkg::FIFO_DEPTH) begin
                    st_next.receive_status_control[
                        ussri_pkg::OVERRUN_BIT] = 1'b1;
                    ev_ovr = 1'b1;
                end else begin
                    st_next.fifo[st_next.fifo_cnt[0]] = st_next.rx_shift;
                    st_next.fifo_cnt = st_next.fifo_cnt + 2'h1;
                    ev_rx = 1'b1;
                end
                st_next.rx_shift = 9'h000;
                // Single receive ends after one character
                if (!st_reg.receive_status_control[
                        ussri_pkg::CONTINUOUS_RECEIVE_BIT]) begin
                    st_next.receive_status_control[
                        ussri_pkg::SINGLE_RECEIVE_BIT] = 1'b0;
                end
            end
        end

        // Sticky events: a set in the clear cycle wins
        st_next.irq_stat[ussri_pkg::EV_RX_CHAR_BIT] =
            st_next.irq_stat[ussri_pkg::EV_RX_CHAR_BIT] | ev_rx;
        st_next.irq_stat[ussri_pkg::EV_TX_READY_BIT] =
            st_next.irq_stat[ussri_pkg::EV_TX_READY_BIT] | ev_tx;
        st_next.irq_stat[ussri_pkg::EV_OVERRUN_BIT] =
            st_next.irq_stat[ussri_pkg::EV_OVERRUN_BIT] | ev_ovr;
        st_next.irq = |(st_reg.irq_stat & st_reg.irq_mask);

        // all three enables gate the request
        st_next.cpu_irq_req =
            st_reg.irq_control_main[ussri_pkg::GLOBAL_IRQ_ENABLE_BIT]
            && st_reg.irq_control_main[ussri_pkg::PERIPH_IRQ_ENABLE_BIT]
            && ((rx_pending_flag && st_reg.periph_irq_enable_one[
                     ussri_pkg::RX_IRQ_ENABLE_BIT])
                || (tx_ready_flag && st_reg.periph_irq_enable_one[
                     ussri_pkg::TX_IRQ_ENABLE_BIT]));
        st_next.wake_req = sleep_mode && tx_ready_flag
            && st_reg.irq_control_main[ussri_pkg::PERIPH_IRQ_ENABLE_BIT]
            && st_reg.periph_irq_enable_one[ussri_pkg::TX_IRQ_ENABLE_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.irq_control_main        <= ussri_pkg::RST_IRQ_CONTROL_MAIN;
            st_reg.periph_irq_enable_one   <= ussri_pkg::RST_PERIPH_IRQ_EN;
            st_reg.receive_status_control  <= ussri_pkg::RST_RECEIVE_STATUS;
            st_reg.transmit_status_control <= ussri_pkg::RST_TRANSMIT_STATUS;
            st_reg.port_c_direction        <= ussri_pkg::RST_PORT_C_DIRECTION;
            st_reg.transmit_holding        <= ussri_pkg::RST_TRANSMIT_HOLDING;
            st_reg.dt_out                  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready      = st_reg.pready;
    assign prdata      = st_reg.prdata;
    assign pslverr     = st_reg.pslverr;
    assign dt_out      = st_reg.dt_out;
    assign dt_oe       = st_reg.dt_oe;
    assign irq         = st_reg.irq;
    assign cpu_irq_req = st_reg.cpu_irq_req;
    assign wake_req    = st_reg.wake_req;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_RX_PENDING: assert property (
        serial_port_enable && $rose(st_reg.fifo_cnt != 2'h0) |-> rx_pending_flag)
        else $error("Pending flag missing with unread character");
    AST_FLAG_READ_ONLY: assert property (
        wr_done && paddr == ussri_pkg::OFF_PERIPH_IRQ_FLAGS
        && st_next.fifo_cnt == st_reg.fifo_cnt && $stable(serial_port_enable)
        |=> $stable(rx_pending_flag))
        else $error("Flag write changed pending flag");
    AST_IRQ_GATE: assert property (
        cpu_irq_req |-> $past(st_reg.irq_control_main[7:6] == 2'h3))
        else $error("Request without global and peripheral enables");
    AST_FLAG_INDEP: assert property (
        !st_reg.periph_irq_enable_one[5] && serial_port_enable
        && st_reg.fifo_cnt != 2'h0 |-> rx_pending_flag && !st_next.cpu_irq_req
        || tx_ready_flag)
        else $error("Pending flag depends on enables");
    AST_TX_MODE: assert property (
        dt_oe |-> $past(!rx_mode && slave_mode))
        else $error("Pin driven outside slave transmit mode");
    AST_SERIAL_PORT_ENABLE_OFF: assert property (
        !serial_port_enable |=> !st_reg.tx_busy && !dt_oe)
        else $error("Slave logic active while disabled");
    AST_TX_LOAD: assert property (
        tx_active && st_reg.hold_full && !st_reg.tx_busy && !wr_done
        |=> st_reg.tx_busy && tx_ready_flag)
        else $error("Held word not moved to shifter");
    AST_TX_HOLD: assert property (
        st_reg.tx_busy && st_reg.hold_full && !ck_fall && tx_active
        |=> st_reg.hold_full)
        else $error("Second word left holding register early");
    AST_WAKE: assert property (
        wake_req |-> $past(sleep_mode && tx_ready_flag))
        else $error("Wake without sleep and ready");
    AST_FIFO_DEPTH: assert property (
        st_reg.fifo_cnt <= ussri_pkg::FIFO_DEPTH)
        else $error("Receive FIFO above two");
    AST_POP: assert property (
        rd_done && paddr == ussri_pkg::OFF_RECEIVE_DATA
        && st_reg.fifo_cnt == 2'h2 && !ev_rx
        |=> st_reg.fifo_cnt == 2'h1)
        else $error("Receive read did not pop");

    COV_RX_CHAR: cover property (ev_rx);
    COV_TX_LOAD: cover property (ev_tx ##[1:1000] ev_tx);
    COV_OVERRUN: cover property (ev_ovr);
    COV_WAKE: cover property ($rose(wake_req));

endmodule : ussri_top

// >>> ussri_pkg.sv
// Package with register map, field positions and state record of the unit
package ussri_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_IRQ_CONTROL_MAIN  = 8'h00;
    localparam logic [7:0] OFF_PERIPH_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] OFF_PERIPH_IRQ_FLAGS  = 8'h08;
    localparam logic [7:0] OFF_RECEIVE_STATUS    = 8'h0C;
    localparam logic [7:0] OFF_TRANSMIT_STATUS   = 8'h10;
    localparam logic [7:0] OFF_TRANSMIT_HOLDING  = 8'h14;
    localparam logic [7:0] OFF_RECEIVE_DATA      = 8'h18;
    localparam logic [7:0] OFF_PORT_C_DIRECTION  = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STATUS        = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK          = 8'h24;

    // Field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT   = 7;
    localparam int PERIPH_IRQ_ENABLE_BIT   = 6;
    localparam int RX_IRQ_ENABLE_BIT       = 5;
    localparam int TX_IRQ_ENABLE_BIT       = 4;
    localparam int RX_PENDING_FLAG_BIT     = 5;
    localparam int TX_READY_FLAG_BIT       = 4;
    localparam int SERIAL_PORT_ENABLE_BIT  = 7;
    localparam int RX_NINE_BIT_ENABLE_BIT  = 6;
    localparam int SINGLE_RECEIVE_BIT      = 5;
    localparam int CONTINUOUS_RECEIVE_BIT  = 4;
    localparam int ADDRESS_DETECT_BIT      = 3;
    localparam int OVERRUN_BIT             = 1;
    localparam int RX_NINTH_BIT            = 0;
    localparam int CLOCK_SOURCE_SELECT_BIT = 7;
    localparam int TX_NINE_BIT_ENABLE_BIT  = 6;
    localparam int TRANSMIT_ENABLE_BIT     = 5;
    localparam int SYNC_MODE_BIT           = 4;
    localparam int TX_SHIFT_EMPTY_BIT      = 1;
    localparam int TX_NINTH_BIT            = 0;
    localparam int EV_RX_CHAR_BIT          = 0;
    localparam int EV_TX_READY_BIT         = 1;
    localparam int EV_OVERRUN_BIT          = 2;

    // Reset values
    localparam logic [7:0] RST_IRQ_CONTROL_MAIN = 8'h00;
    localparam logic [7:0] RST_PERIPH_IRQ_EN    = 8'h00;
    localparam logic [7:0] RST_RECEIVE_STATUS   = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS  = 8'h02;
    localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_TRANSMIT_HOLDING = 8'h00;

    // Character lengths and FIFO depth
    localparam logic [3:0] CHAR_BITS_EIGHT = 4'h8;
    localparam logic [3:0] CHAR_BITS_NINE  = 4'h9;
    localparam logic [1:0] FIFO_DEPTH      = 2'h2;

    typedef struct packed {
        logic [7:0]      irq_control_main;
        logic [7:0]      periph_irq_enable_one;
        logic [7:0]      receive_status_control;
        logic [7:0]      transmit_status_control;
        logic [7:0]      port_c_direction;
        logic [7:0]      transmit_holding;
        logic            hold_ninth;
        logic            hold_full;
        logic [8:0]      transmit_shift_register;
        logic [3:0]      tx_cnt;
        logic            tx_busy;
        logic [8:0]      rx_shift;
        logic [3:0]      rx_cnt;
        logic [1:0][8:0] fifo;
        logic [1:0]      fifo_cnt;
        logic            ck_s1;
        logic            ck_s2;
        logic            ck_s3;
        logic            dt_s1;
        logic            dt_s2;
        logic            dt_out;
        logic            dt_oe;
        logic [2:0]      irq_stat;
        logic [2:0]      irq_mask;
        logic            irq;
        logic            cpu_irq_req;
        logic            wake_req;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } ussri_state_t;

endpackage : ussri_pkg

// >>> ussri_link_master.sv
// External synchronous master that clocks frames through the unit
`timescale 1ns/1ps
module ussri_link_master (
    output logic link_ck,
    output logic dt_in,
    input  wire logic dt_out
);
    initial begin
        link_ck = 1'b0;
        dt_in   = 1'b1;
    end

    // master makes clock
    // Clock idles low between frames; data goes LSB first
    task automatic frame(input logic [8:0] tx, input int n,
                         output logic [8:0] rx);
        rx = 9'h000;
        // Offset keeps link edges clear of core clock edges
        #10;
        for (int i = 0; i < n; i++) begin
            #80;
            dt_in = tx[i];
            #80;
            // Previous bit stays until the device sees this rise
            if (i > 0) rx[i-1] = dt_out;
            link_ck = 1'b1;
            #160;
            link_ck = 1'b0;
        end
        #160;
        rx[n-1] = dt_out;
        // Released line shows no stale level
        dt_in = ~dt_in;
    endtask : frame
endmodule : ussri_link_master

// >>> ussri_top_tb.sv
// Register level bench for the synchronous slave unit
`timescale 1ns/1ps
module ussri_top_tb;
    logic core_clk, sys_rst, psel, penable, pwrite, sleep_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, link_ck, dt_in, dt_out, dt_oe;
    logic irq, cpu_irq_req, wake_req, err;
    logic [8:0] rx;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h1C, 8'h14};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h00};

    ussri_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .link_ck(link_ck), .dt_in(dt_in),
        .dt_out(dt_out), .dt_oe(dt_oe), .irq(irq),
        .cpu_irq_req(cpu_irq_req), .wake_req(wake_req));
    ussri_link_master i_mst (.link_ck(link_ck), .dt_in(dt_in),
        .dt_out(dt_out));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-raises psel at once
        @(posedge core_clk);
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_clk

    initial begin
        {sys_rst, psel, penable, pwrite, sleep_mode} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0;
        wait_clk(12);
        sys_rst <= 1'b0;
        wait_clk(1);
        foreach (ra[i]) rd(ra[i], {24'h0, rv[i]});
        rd(8'h30, 32'h0);
        chk(err, 1'b1);
        chk(dt_oe, 1'b0);
        $display("test reset done");
        apb(ussri_pkg::OFF_TRANSMIT_STATUS, 1'b1, 32'h10);
        apb(ussri_pkg::OFF_RECEIVE_STATUS, 1'b1, 32'h90);
        chk(dt_oe, 1'b0);
        i_mst.frame(9'h0A5, 8, rx);
        i_mst.frame(9'h03C, 8, rx);
        i_mst.frame(9'h0FF, 8, rx);
        wait_clk(8);
        rd(ussri_pkg::OFF_RECEIVE_STATUS, 32'h92);
        rd(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 32'h30);
        apb(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 1'b1, 32'h00);
        rd(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 32'h30);
        chk(cpu_irq_req, 1'b0);
        apb(ussri_pkg::OFF_PERIPH_IRQ_ENABLE, 1'b1, 32'h20);
        apb(ussri_pkg::OFF_IRQ_CONTROL_MAIN, 1'b1, 32'hC0);
        wait_clk(2);
        chk(cpu_irq_req, 1'b1);
        rd(ussri_pkg::OFF_IRQ_STATUS, 32'h05);
        apb(ussri_pkg::OFF_IRQ_MASK, 1'b1, 32'h01);
        wait_clk(2);
        chk(irq, 1'b1);
        rd(ussri_pkg::OFF_RECEIVE_DATA, 32'hA5);
        rd(ussri_pkg::OFF_RECEIVE_DATA, 32'h3C);
        rd(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 32'h10);
        apb(ussri_pkg::OFF_IRQ_STATUS, 1'b1, 32'h01);
        wait_clk(2);
        chk(irq, 1'b0);
        $display("test receive done");
        apb(ussri_pkg::OFF_IRQ_CONTROL_MAIN, 1'b1, 32'h40);
        apb(ussri_pkg::OFF_PERIPH_IRQ_ENABLE, 1'b1, 32'h10);
        apb(ussri_pkg::OFF_RECEIVE_STATUS, 1'b1, 32'h80);
        apb(ussri_pkg::OFF_TRANSMIT_STATUS, 1'b1, 32'h71);
        wait_clk(2);
        chk(dt_oe, 1'b1);
        sleep_mode <= 1'b1;
        apb(ussri_pkg::OFF_TRANSMIT_HOLDING, 1'b1, 32'h5A);
        apb(ussri_pkg::OFF_TRANSMIT_HOLDING, 1'b1, 32'h96);
        wait_clk(2);
        rd(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 32'h00);
        rd(ussri_pkg::OFF_TRANSMIT_STATUS, 32'h71);
        chk(wake_req, 1'b0);
        i_mst.frame(9'h000, 9, rx);
        chk(rx, 9'h15A);
        wait_clk(6);
        rd(ussri_pkg::OFF_PERIPH_IRQ_FLAGS, 32'h10);
        chk({wake_req, cpu_irq_req}, 2'b10);
        i_mst.frame(9'h000, 9, rx);
        chk(rx, 9'h196);
        wait_clk(6);
        rd(ussri_pkg::OFF_TRANSMIT_STATUS, 32'h73);
        $display("test transmit done");
        stop_test();
    end
endmodule : ussri_top_tb
